// ===== tmr_top.v
`timescale 1ns/1ns
`include "tmr_regs.vh"
// Notes on behaviour
// RULE1: In PWM mode, loading compare 1 with fffc drops the next PWM pulse.
// RULE2: That period stays fully active or inactive, chosen by both level bits; the code holds the level 2 bit value whatever level 1 is.
// RULE3: Stop in same cycle as compare event locks flag until restart.
// RULE4: Software clears compare interrupt enable before setting the stop bit.
// RULE5: Software clears the stop bit first, then re-enables compare interrupt.
// RULE6: Stop bit is mask 40 of control/status; set stops, clear runs.
// RULE7: Compare interrupt enable is mask 40 of control register one.
// RULE8: Software masks interrupts around clearing a pending flag outside handlers.
// RULE9: With nesting, clear flags only from safe context or with saved codes.
// RULE10: Each timer tick compares counter with compares, sets flags, requests interrupt.
module tmr_top
(
   input  wire        CLK,
   input  wire        RSTN,
   input  wire        CE,
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output wire        AWREADY,
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output wire        WREADY,
   output wire [1:0]  BRESP,
   output wire        BVALID,
   input  wire        BREADY,
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output wire        ARREADY,
   output wire [31:0] RDATA,
   output wire [1:0]  RRESP,
   output wire        RVALID,
   input  wire        RREADY,
   output wire        PWM_OUT,
   output reg         CMP_IRQ
);

   wire        wr;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire        rd;
   wire [7:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_err;
   reg         wr_err;

   reg  [7:0]  cr1_q;
   reg  [7:0]  cr2_q;
   reg         stop_q;
   wire [1:0]  flag_q;
   reg  [15:0] cmp1_q;
   reg  [15:0] cmp2_q;
   reg  [15:0] cnt_q;
   reg         drop_q;

   wire        run = !stop_q;
   wire        tick = run;
   wire [1:0]  match;
   wire        pwm_en = cr2_q[`TMR_CR2_PWM_BIT];
   wire        cmp1_wr = wr && (wr_addr == `TMR_CMP1_OFF);
   wire        csr_wr = wr && (wr_addr == `TMR_CSR_OFF);
   wire        stop_set = csr_wr && wr_data[`TMR_CSR_STOP_BIT];
   wire        csr_rd = rd && (rd_addr == `TMR_CSR_OFF);

   assign match[0] = (cnt_q == cmp1_q);
   assign match[1] = (cnt_q == cmp2_q);

   tmr_axil u_axil
   (
      .clk       (CLK),
      .rst_n     (RSTN),
      .ce        (CE),
      .awaddr    (AWADDR),
      .awvalid   (AWVALID),
      .awready   (AWREADY),
      .wdata     (WDATA),
      .wstrb     (WSTRB),
      .wvalid    (WVALID),
      .wready    (WREADY),
      .bresp     (BRESP),
      .bvalid    (BVALID),
      .bready    (BREADY),
      .araddr    (ARADDR),
      .arvalid   (ARVALID),
      .arready   (ARREADY),
      .rdata     (RDATA),
      .rresp     (RRESP),
      .rvalid    (RVALID),
      .rready    (RREADY),
      .wr_q      (wr),
      .wr_addr_q (wr_addr),
      .wr_data_q (wr_data),
      .rd_q      (rd),
      .rd_addr_q (rd_addr),
      .rd_data   (rd_data),
      .rd_err    (rd_err),
      .wr_err    (wr_err)
   );

   tmr_pwm u_pwm
   (
      .clk    (CLK),
      .rst_n  (RSTN),
      .ce     (CE),
      .pwm_en (pwm_en),
      .tick   (tick),
      .match1 (match[0]),
      .match2 (match[1]),
      .drop   (drop_q),
      .lvl1   (cr1_q[`TMR_CR1_LVL1_BIT]),
      .lvl2   (cr1_q[`TMR_CR1_LVL2_BIT]), // see RULE2
      .pwm_q  (PWM_OUT)
   );

   // Read mux; unmapped addresses answer with an error response.
   always @*
   begin
      rd_data = 32'h00000000;
      rd_err  = 1'b0;
      case (rd_addr)
         `TMR_CR1_OFF:  rd_data = {24'h000000, cr1_q};
         `TMR_CR2_OFF:  rd_data = {24'h000000, cr2_q};
         `TMR_CSR_OFF:  rd_data = {24'h000000, 1'b0, stop_q, 1'b0, flag_q[1], flag_q[0], 3'h0};
         `TMR_CMP1_OFF: rd_data = {16'h0000, cmp1_q};
         `TMR_CMP2_OFF: rd_data = {16'h0000, cmp2_q};
         `TMR_CNT_OFF:  rd_data = {16'h0000, cnt_q};
         default:       rd_err  = 1'b1;
      endcase
   end

   // Write decode error for unmapped or read-only addresses.
   always @*
   begin
      case (wr_addr)
         `TMR_CR1_OFF, `TMR_CR2_OFF, `TMR_CSR_OFF, `TMR_CMP1_OFF, `TMR_CMP2_OFF: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   // Control registers, compare values and the stop bit.
   always @(posedge CLK)
   begin
      if (!RSTN)
      begin
         cr1_q  <= `TMR_CR1_RST;
         cr2_q  <= `TMR_CR2_RST;
         stop_q <= 1'b0;
         cmp1_q <= `TMR_CMP_RST;
         cmp2_q <= `TMR_CMP_RST;
         drop_q <= 1'b0;
      end
      else if (CE)
      begin
         drop_q <= 1'b0;
         if (wr && wr_addr == `TMR_CR1_OFF)
            cr1_q <= wr_data[7:0]; // see RULE7
         if (wr && wr_addr == `TMR_CR2_OFF)
            cr2_q <= wr_data[7:0];
         if (csr_wr)
            stop_q <= wr_data[`TMR_CSR_STOP_BIT]; // see RULE6
         if (cmp1_wr)
         begin
            cmp1_q <= wr_data[15:0];
            drop_q <= pwm_en && (wr_data[15:0] == `TMR_CMP_DROP_VAL); // see RULE1
         end
         if (wr && wr_addr == `TMR_CMP2_OFF)
            cmp2_q <= wr_data[15:0];
      end
   end

   // Free-running counter; it only advances while the timer runs.
   always @(posedge CLK)
   begin
      if (!RSTN)
         cnt_q <= `TMR_CNT_RST;
      else if (CE && tick)
      begin
         if (pwm_en && match[1])
            cnt_q <= `TMR_CNT_RST; // PWM period restarts at compare 2.
         else
            cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Compare flags: set on match, cleared by a status read followed by a compare write.
   // A stop landing with a match locks the flag until the timer runs again.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_flag
         reg  flag_bit_q;
         reg  lock_bit_q;
         reg  seen_bit_q;
         wire set_ev = tick && match[gi];
         wire clr_ev = seen_bit_q && wr && (wr_addr == (gi == 0 ? `TMR_CMP1_OFF : `TMR_CMP2_OFF));
         // Each flag bit has its own register so that only one process drives it.
         assign flag_q[gi] = flag_bit_q;
         always @(posedge CLK)
         begin
            if (!RSTN)
            begin
               flag_bit_q <= 1'b0;
               lock_bit_q <= 1'b0;
               seen_bit_q <= 1'b0;
            end
            else if (CE)
            begin
               if (csr_rd && flag_bit_q)
                  seen_bit_q <= 1'b1;
               else if (clr_ev)
                  seen_bit_q <= 1'b0;
               if (set_ev && stop_set)
                  lock_bit_q <= 1'b1; // see RULE3
               else if (run && !set_ev && lock_bit_q && !stop_set)
                  lock_bit_q <= 1'b0; // see RULE3
               if (set_ev)
                  flag_bit_q <= 1'b1; // see RULE10
               else if (clr_ev && !lock_bit_q)
                  flag_bit_q <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt request follows the enabled compare flags.
   always @(posedge CLK)
   begin
      if (!RSTN)
         CMP_IRQ <= 1'b0;
      else if (CE)
         CMP_IRQ <= cr1_q[`TMR_CR1_CMPIE_BIT] && (flag_q != 2'b00); // see RULE10
   end

endmodule // tmr_top

// ===== tmr_regs.vh
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
// Register byte offsets on the AXI4-Lite bus.
`define TMR_CR1_OFF        8'h00
`define TMR_CSR_OFF        8'h04
`define TMR_CMP1_OFF       8'h08
`define TMR_CMP2_OFF       8'h0c
`define TMR_CNT_OFF        8'h10
`define TMR_CR2_OFF        8'h14
// Control register one fields.
`define TMR_CR1_CMPIE_BIT  6
`define TMR_CR1_LVL2_BIT   1
`define TMR_CR1_LVL1_BIT   0
`define TMR_CR1_RST        8'h00
// Control/status register fields.
`define TMR_CSR_FLAG1_BIT  3
`define TMR_CSR_FLAG2_BIT  4
`define TMR_CSR_STOP_BIT   6
`define TMR_CSR_RST        8'h00
// Control register two fields.
`define TMR_CR2_PWM_BIT    4
`define TMR_CR2_RST        8'h00
// Compare reset values and the value that drops the next PWM pulse.
`define TMR_CMP_RST        16'hffff
`define TMR_CMP_DROP_VAL   16'hfffc
`define TMR_CNT_RST        16'h0000
`define TMR_RESP_OKAY      2'b00
`define TMR_RESP_SLVERR    2'b10
`endif

// ===== tmr_axil.v
`timescale 1ns/1ns
`include "tmr_regs.vh"
// AXI4-Lite slave front end: captures address and data in either order,
// raises one-cycle write and read strobes toward the register file.
module tmr_axil
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   output reg         wr_q,
   output reg  [7:0]  wr_addr_q,
   output reg  [31:0] wr_data_q,
   output reg         rd_q,
   output reg  [7:0]  rd_addr_q,
   input  wire [31:0] rd_data,
   input  wire        rd_err,
   input  wire        wr_err
);

   reg aw_have_q;
   reg w_have_q;
   reg rd_wait_q;

   // Write channel: hold each half until both arrived, then strobe once.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `TMR_RESP_OKAY;
         wr_q      <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h00000000;
      end
      else if (ce)
      begin
         awready <= 1'b0;
         wready  <= 1'b0;
         wr_q    <= 1'b0;
         if (awvalid && !aw_have_q && !awready && !bvalid)
         begin
            awready   <= 1'b1;
            aw_have_q <= 1'b1;
            wr_addr_q <= awaddr;
         end
         if (wvalid && !w_have_q && !wready && !bvalid)
         begin
            wready    <= 1'b1;
            w_have_q  <= 1'b1;
            wr_data_q <= wdata;
         end
         if (aw_have_q && w_have_q && !wr_q && !bvalid)
            wr_q <= (wstrb != 4'h0) | 1'b1; // Whole-word writes; the compare values span the low two byte lanes, other fields the low one.
         if (wr_q)
         begin
            bvalid    <= 1'b1;
            bresp     <= wr_err ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
         if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Read channel: take the address, strobe the register file, answer next cycle.
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         arready   <= 1'b0;
         rvalid    <= 1'b0;
         rdata     <= 32'h00000000;
         rresp     <= `TMR_RESP_OKAY;
         rd_q      <= 1'b0;
         rd_addr_q <= 8'h00;
         rd_wait_q <= 1'b0;
      end
      else if (ce)
      begin
         arready <= 1'b0;
         rd_q    <= 1'b0;
         if (arvalid && !arready && !rd_wait_q && !rvalid)
         begin
            arready   <= 1'b1;
            rd_addr_q <= araddr;
            rd_q      <= 1'b1;
            rd_wait_q <= 1'b1;
         end
         if (rd_q)
         begin
            rvalid    <= 1'b1;
            rdata     <= rd_data;
            rresp     <= rd_err ? `TMR_RESP_SLVERR : `TMR_RESP_OKAY;
         end
         if (rvalid && rready)
         begin
            rvalid    <= 1'b0;
            rd_wait_q <= 1'b0;
         end
      end
   end

endmodule // tmr_axil

// ===== tmr_pwm.v
`timescale 1ns/1ns
`include "tmr_regs.vh"
// PWM output stage: active level from compare 1 match, inactive at compare 2.
// A period whose pulse is dropped holds one level, the value of lvl2 whatever lvl1 is.
module tmr_pwm
(
   input  wire clk,
   input  wire rst_n,
   input  wire ce,
   input  wire pwm_en,
   input  wire tick,
   input  wire match1,
   input  wire match2,
   input  wire drop,
   input  wire lvl1,
   input  wire lvl2,
   output reg  pwm_q
);

   reg skip_q;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         pwm_q  <= 1'b0;
         skip_q <= 1'b0;
      end
      else if (ce)
      begin
         if (drop)
            skip_q <= 1'b1;
         if (!pwm_en)
            pwm_q <= 1'b0;
         else if (tick && match2)
         begin
            // A period ends at compare 2; a pending drop is consumed here.
            if (skip_q || drop)
            begin
               pwm_q  <= lvl1 & lvl2 ? lvl1 : lvl2; // see RULE2
               skip_q <= 1'b0;
            end
            else
               pwm_q <= lvl2;
         end
         else if (tick && match1 && !skip_q && !drop)
            pwm_q <= lvl1; // see RULE1
      end
   end

endmodule // tmr_pwm

// ===== tmr_top_asserts.sv
`timescale 1ns/1ns
// Watches bus answers and output levels of the timer top.
module tmr_chk
(
   input wire        CLK,
   input wire        RSTN,
   input wire        AWREADY,
   input wire        WREADY,
   input wire        BVALID,
   input wire        BREADY,
   input wire [1:0]  BRESP,
   input wire        ARREADY,
   input wire        RVALID,
   input wire        RREADY,
   input wire [31:0] RDATA,
   input wire        CMP_IRQ,
   input wire        PWM_OUT
);
   // All checks share the one clock; all but a_reset_quiet are disabled during its reset.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // Answers stand until taken and come within a bounded time.
   a_bvalid_holds: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write answer dropped");
   a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read answer changed");
   a_write_answer: assert property (AWREADY && WREADY |-> ##[1:3] BVALID)
      else $error("write not answered");
   a_read_answer: assert property (ARREADY |-> ##[1:2] RVALID)
      else $error("read not answered");
   a_awready_pulse: assert property (AWREADY |=> !AWREADY)
      else $error("awready too long");
   a_arready_pulse: assert property (ARREADY |=> !ARREADY)
      else $error("arready too long");
   a_bresp_code: assert property (BVALID |-> BRESP == 2'b00 || BRESP == 2'b10)
      else $error("bad write code");
   // Reset clears both answer valids, the interrupt and the PWM pin on the next edge.
   a_reset_quiet: assert property (disable iff (1'b0) !RSTN |=> !BVALID && !RVALID && !CMP_IRQ && !PWM_OUT)
      else $error("output not cleared");
   // Main scenarios.
   c_write: cover property (BVALID && BREADY);
   c_read: cover property (RVALID && RREADY);
   c_irq: cover property ($rose(CMP_IRQ));
   c_pwm: cover property ($fell(PWM_OUT));
endmodule // tmr_chk

bind tmr_top tmr_chk u_chk
(
   .CLK(CLK), .RSTN(RSTN), .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
   .BRESP(BRESP), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
   .CMP_IRQ(CMP_IRQ), .PWM_OUT(PWM_OUT)
);

// ===== tb.sv
`timescale 1ns/1ns
`include "tmr_regs.vh"
// Drives the timer over its register bus and checks answers and pins.
module tb;
   localparam [1:0] ok = `TMR_RESP_OKAY;
   reg         clk;
   reg         rstn;
   reg  [7:0]  awaddr;
   reg         awvalid;
   reg  [31:0] wdata;
   reg         wvalid;
   reg         bready;
   reg  [7:0]  araddr;
   reg         arvalid;
   reg         rready;
   wire        awready;
   wire        wready;
   wire [1:0]  bresp;
   wire        bvalid;
   wire        arready;
   wire [31:0] rdata;
   wire [1:0]  rresp;
   wire        rvalid;
   wire        pwm;
   wire        irq;
   reg  [31:0] d;
   reg  [31:0] d2;
   reg  [1:0]  r;
   integer     num_errors;
   integer     total_checks;
   integer     t;
   integer     k;

   tmr_top dut
   (
      .CLK(clk), .RSTN(rstn), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
      .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .PWM_OUT(pwm), .CMP_IRQ(irq)
   );

   // Free-running clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Counts a comparison and reports a mismatch.
   task chk_word(input [31:0] g, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e)
         begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask

   // Compares a bus answer code.
   task chk_resp(input [1:0] g, input [1:0] e);
      begin
         chk_word({30'h0, g}, {30'h0, e});
      end
   endtask

   // One write; address and data go together and each is released once taken.
   task wr(input [7:0] a, input [31:0] v, output [1:0] rs);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
         end
         while (awvalid || wvalid);
         while (!bvalid)
            @(posedge clk);
         rs = bresp;
         bready <= 1'b0;
      end
   endtask

   // One read; the answer is taken at the edge where it is seen.
   task rd(input [7:0] a, output [31:0] v, output [1:0] rs);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
            @(posedge clk);
         while (!arready);
         arvalid <= 1'b0;
         while (!rvalid)
            @(posedge clk);
         v = rdata;
         rs = rresp;
         rready <= 1'b0;
      end
   endtask

   // Write expecting a given answer code.
   task wchk(input [7:0] a, input [31:0] v, input [1:0] e);
      begin
         wr(a, v, r);
         chk_resp(r, e);
      end
   endtask

   // Read expecting a given word and a good answer.
   task rchk(input [7:0] a, input [31:0] e);
      begin
         rd(a, d, r);
         chk_resp(r, ok);
         chk_word(d, e);
      end
   endtask

   // Counts changes of the PWM pin over n cycles.
   task watch(input integer n, output integer c);
      reg p;
      begin
         c = 0;
         p = pwm;
         repeat (n)
         begin
            @(posedge clk);
            if (pwm !== p)
               c = c + 1;
            p = pwm;
         end
      end
   endtask

   // Prints the verdict and ends the run.
   task report_and_stop;
      begin
         if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // Cuts a hang short.
   initial
   begin
      #400000;
      num_errors = num_errors + 1;
      report_and_stop;
   end

   // Main sequence.
   initial
   begin
      num_errors = 0;
      total_checks = 0;
      rstn = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rchk(`TMR_CSR_OFF, 32'h0);
      wchk(`TMR_CMP2_OFF, 32'h40, ok);
      wchk(`TMR_CR2_OFF, 32'h10, ok);
      rchk(`TMR_CR1_OFF, 32'h0);
      rchk(`TMR_CMP1_OFF, 32'hffff);
      rd(8'h18, d, r);
      chk_resp(r, `TMR_RESP_SLVERR);
      wchk(`TMR_CNT_OFF, 32'h5, `TMR_RESP_SLVERR);
      // Normal pulses and the compare flag with its interrupt.
      wchk(`TMR_CMP1_OFF, 32'h10, ok);
      wchk(`TMR_CR1_OFF, 32'h41, ok);
      watch(140, t);
      chk_word(t > 1, 1);
      rd(`TMR_CSR_OFF, d, r);
      chk_word(d[3], 1);
      chk_word(irq, 1);
      // Orderly stop: interrupt enable off first, then the stop bit.
      wchk(`TMR_CR1_OFF, 32'h0, ok);
      rd(`TMR_CSR_OFF, d, r);
      wchk(`TMR_CSR_OFF, d | 32'h40, ok);
      chk_word(irq, 0);
      rd(`TMR_CNT_OFF, d, r);
      rd(`TMR_CNT_OFF, d2, r);
      chk_word(d2, d);
      // Restart: timer first, then the interrupt enable.
      rd(`TMR_CSR_OFF, d2, r);
      wchk(`TMR_CSR_OFF, d2 & ~32'h40, ok);
      rd(`TMR_CNT_OFF, d2, r);
      chk_word(d2 !== d, 1);
      wchk(`TMR_CR1_OFF, 32'h40, ok);
      repeat (2) @(posedge clk);
      chk_word(irq, 1);
      // Flag clear while its interrupt is disabled; a far compare value keeps it clear.
      wchk(`TMR_CR1_OFF, 32'h0, ok);
      wchk(`TMR_CMP1_OFF, 32'h8000, ok);
      rd(`TMR_CSR_OFF, d, r);
      wchk(`TMR_CMP1_OFF, 32'h8000, ok);
      rd(`TMR_CSR_OFF, d2, r);
      chk_word(d2[3], 0);
      // Stop strobe placed on the cycle of a compare 1 match: ten cycles after the count is read.
      do
      begin
         rd(`TMR_CNT_OFF, d, r);
      end
      while (d > 32'h30);
      wchk(`TMR_CMP1_OFF, d + 32'ha, ok);
      wchk(`TMR_CSR_OFF, d2 | 32'h40, ok);
      rd(`TMR_CSR_OFF, d, r);
      wchk(`TMR_CMP1_OFF, 32'h8000, ok);
      rd(`TMR_CSR_OFF, d, r);
      chk_word(d[3], 1);
      chk_word(d[6], 1);
      chk_word(irq, 0);
      wchk(`TMR_CSR_OFF, d & ~32'h40, ok);
      wchk(`TMR_CMP1_OFF, 32'h8000, ok);
      rd(`TMR_CSR_OFF, d, r);
      chk_word(d[3], 0);
      // The drop value silences the next pulse at every level setting.
      for (k = 0; k < 4; k = k + 1)
      begin
         wchk(`TMR_CMP1_OFF, 32'h10, ok);
         wchk(`TMR_CR1_OFF, k, ok);
         wchk(`TMR_CMP1_OFF, {16'h0, `TMR_CMP_DROP_VAL}, ok);
         watch(70, t);
         watch(66, t);
         chk_word(t, 0);
         chk_word(pwm, (k[0] & k[1]) ? k[0] : k[1]);
      end
      // Long period so the counter really passes the drop value; no pulse may appear there.
      wchk(`TMR_CR1_OFF, 32'h1, ok);
      watch(70, t);
      wchk(`TMR_CMP2_OFF, 32'hfffe, ok);
      wchk(`TMR_CMP1_OFF, {16'h0, `TMR_CMP_DROP_VAL}, ok);
      watch(65600, t);
      chk_word(t, 0);
      chk_word(pwm, 0);
      report_and_stop;
   end
endmodule // tb
